// File: src/flash_cmd_regs.svh
// Purpose: Opcodes, bit positions, reset values and timing for the config/status command block
// Assumes: 50 MHz core clock
// Notes:   Included by bare name; definitions only
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ==========================================================
// Opcodes
`define OP_CFG_READ      8'h15
`define OP_CFG_READ_D    8'h45
`define OP_READY_INT     8'h25
`define OP_STATUS_WR0    8'h01
`define OP_STATUS_WR1    8'h31
`define OP_WRITE_EN      8'h06
`define OP_WRITE_DIS     8'h04
`define OP_CFG_WRITE     8'h11
`define OP_PAGE_ERASE    8'h81

// ==========================================================
// Status word bit positions and masks
`define ST_WIP           0
`define ST_WEL           1
`define ST_PROTECT_MODE_BIT0          7
`define ST_PROTECT_MODE_BIT1          8
`define ST_QE            9
`define ST_CMP           14
`define ST_LB_HI         13
`define ST_LB_LO         11
`define ST_KEEP_MASK     16'h8403
`define STATUS_RESET     16'h0000

// ==========================================================
// Configure register bit positions, mask and reset
`define CF_HOLD_RST      7
`define CF_DRV_HI        6
`define CF_DRV_LO        5
`define CF_QP            4
`define CF_WPS           2
`define CF_WR_MASK       8'hf4
`define CFG_RESET        8'h40

// ==========================================================
// Frame bit counts, page masks, lock bits
`define BITS_OP          6'd8
`define BITS_ONE         6'd16
`define BITS_TWO         6'd24
`define BITS_ERASE       6'd32
`define BITS_SAT         6'h3f
`define PAGE_MASK_256    10'h0ff
`define PAGE_MASK_1K     10'h3ff
`define LOCK_BITS        16

// ==========================================================
// Timing
`define CLK_PERIOD_NS        20
`define STATUS_WRITE_TIME_NS 5000000

`endif

// File: src/flash_cmd_pkg.sv
// Purpose: Types shared by the config/status command block
// Assumes: Constants live in flash_cmd_regs.svh
// Notes:   Types only
package flash_cmd_pkg;

	// ==========================================================
	// Link modes, write-cycle states, command kinds, drive levels
	typedef enum logic [1:0] {LK_CMD, LK_CFG, LK_ASI} link_mode_t;
	typedef enum logic {WS_IDLE, WS_BUSY} write_state_t;
	typedef enum logic [3:0] {
		CK_NONE, CK_CFG_READ, CK_READY_INT, CK_STATUS_WR0, CK_STATUS_WR1,
		CK_WRITE_EN, CK_WRITE_DIS, CK_CFG_WRITE, CK_PAGE_ERASE
	} cmd_kind_t;
	typedef enum logic [1:0] {DRV_50, DRV_75, DRV_100, DRV_150} strength_t;

endpackage

// File: src/flash_config_status_register_cmds.sv
// Purpose: Config read, ready interrupt and status write handling of a serial flash
// Assumes: sck only toggles while cs_n is low; cfg/shift data are quiet across frame edges
// Notes:   Link logic on sck, register state on clock
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"

// Overview of operation
// - Config read works even while busy
// - Config byte on serial output only
// - Read opcode 15h, or 45h in D
// - Pin is hold/reset or quad data
// - Drive strength from two config bits, fixed at DRV_100 in D
// - Quad page bit picks 256/1024 page
// - Load address wraps at page size
// - Page erase 81h covers quad page
// - Scheme bit picks range or block locks
// - Block lock bits reset to one
// - Ready interrupt drives busy on output
// - Interrupt output only falls, never rises
// - Chip select rise ends output, floats
// - 01h loads low, 31h high byte (31h not decoded in D)
// - Status write needs write enable latch
// - Bits 15,10,1,0 never written
// - Only 8 or 16 data bits accepted
// - Eight bits clears complement, quad, mode1
// - Chip select rise starts timed cycle
// - Hardware protected mode refuses status writes
// - Mode 01 locks while protect low
module flash_config_status_register_cmds #(
	parameter bit D_VARIANT  = 1'b0,
	parameter int TW_CYCLES  = `STATUS_WRITE_TIME_NS / `CLK_PERIOD_NS
) (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    sck,
	input  wire logic                    cs_n,
	input  wire logic                    si,
	output wire logic                    so,
	output logic                         so_oe,
	input  wire logic                    wp_n,
	input  wire logic [9:0]              load_addr,
	input  wire logic                    lock_wr,
	input  wire logic [3:0]              lock_idx,
	input  wire logic                    lock_val,
	output logic                         hold_fn,
	output logic                         reset_fn,
	output logic                         quad_io,
	output flash_cmd_pkg::strength_t     drive_level,
	output logic                         page_1k,
	output logic [9:0]                   buf_addr,
	output logic                         lock_by_blocks,
	output logic [`LOCK_BITS-1:0]        block_lock,
	output logic                         erase_req,
	output logic                         erase_quad,
	output logic [15:0]                  status_word
);

	// ==========================================================
	// Opcode decoding, shared by link and core
	function automatic flash_cmd_pkg::cmd_kind_t op_kind(input logic [7:0] op);
		flash_cmd_pkg::cmd_kind_t k;
		k = flash_cmd_pkg::CK_NONE;
		if (op == (D_VARIANT ? `OP_CFG_READ_D : `OP_CFG_READ))
			k = flash_cmd_pkg::CK_CFG_READ;
		else if (op == `OP_READY_INT)
			k = flash_cmd_pkg::CK_READY_INT;
		else if (op == `OP_STATUS_WR0)
			k = flash_cmd_pkg::CK_STATUS_WR0;
		else if (op == `OP_STATUS_WR1 && !D_VARIANT)
			k = flash_cmd_pkg::CK_STATUS_WR1;
		else if (op == `OP_WRITE_EN)
			k = flash_cmd_pkg::CK_WRITE_EN;
		else if (op == `OP_WRITE_DIS)
			k = flash_cmd_pkg::CK_WRITE_DIS;
		else if (op == `OP_CFG_WRITE)
			k = flash_cmd_pkg::CK_CFG_WRITE;
		else if (op == `OP_PAGE_ERASE)
			k = flash_cmd_pkg::CK_PAGE_ERASE;
		return k;
	endfunction

	logic                          first_ff;
	logic [5:0]                    nbits_ff;
	logic [31:0]                   shift_ff;
	flash_cmd_pkg::link_mode_t     mode_ff;
	logic [2:0]                    bitpos_ff;
	logic                          rd_bit_ff;
	logic [7:0]                    cfg_ff;
	logic [15:0]                   status_ff;
	logic                          rs1_ff;
	logic                          rs2_ff;
	logic                          cs_m_ff;
	logic                          cs_s_ff;
	logic                          cs_d_ff;
	logic                          wp_m_ff;
	logic                          wp_s_ff;
	flash_cmd_pkg::write_state_t   wstate_ff;
	logic [31:0]                   tmr_ff;
	logic [7:0]                    op;
	logic [7:0]                    d_a;
	logic [7:0]                    d_b;
	flash_cmd_pkg::cmd_kind_t      kind;
	logic                          cs_end;
	logic                          busy;
	logic                          hw_lock;
	logic                          can_write;
	logic                          start_sr0;
	logic                          start_sr1;
	logic                          start_cr;
	logic                          start_erase;
	logic                          cycle_done;
	logic [15:0]                   merged;
	logic [15:0]                   nxt_status;

	// ==========================================================
	// Link side (sck domain)

	// Frame start marker; cs_n high presets it
	always_ff @(posedge sck or posedge cs_n)
	begin
		if (cs_n)
			first_ff <= 1'b1;
		else
			first_ff <= 1'b0;
	end

	// Bit count and shift-in; kept after cs_n rises so the core can read it
	always_ff @(posedge sck)
	begin
		if (first_ff)
			nbits_ff <= 6'd1;
		else if (nbits_ff != `BITS_SAT)
			nbits_ff <= nbits_ff + 6'd1;  // Saturates: long frames never look valid
		shift_ff <= {shift_ff[30:0], si};
	end

	// Output side on falling sck; cs_n high ends any mode and floats the pin
	always_ff @(negedge sck or posedge cs_n)
	begin
		if (cs_n)
		begin
			mode_ff   <= flash_cmd_pkg::LK_CMD;
			so_oe     <= 1'b0;
			bitpos_ff <= 3'd7;
			rd_bit_ff <= 1'b0;
		end
		else if (mode_ff == flash_cmd_pkg::LK_CMD && !first_ff && nbits_ff == `BITS_OP)
		begin
			if (op_kind(shift_ff[7:0]) == flash_cmd_pkg::CK_CFG_READ)
			begin
				mode_ff   <= flash_cmd_pkg::LK_CFG;
				so_oe     <= 1'b1;
				rd_bit_ff <= cfg_ff[7];
				bitpos_ff <= 3'd6;
			end
			else if (op_kind(shift_ff[7:0]) == flash_cmd_pkg::CK_READY_INT)
			begin
				mode_ff <= flash_cmd_pkg::LK_ASI;
				so_oe   <= 1'b1;
			end
		end
		else if (mode_ff == flash_cmd_pkg::LK_CFG)
		begin
			rd_bit_ff <= cfg_ff[bitpos_ff];
			bitpos_ff <= bitpos_ff - 3'd1;   // Wraps to repeat the byte
		end
	end

	// Interrupt mode follows the busy flop with no sck edges needed
	assign so = (mode_ff == flash_cmd_pkg::LK_ASI) ? status_ff[`ST_WIP] : rd_bit_ff;

	// ==========================================================
	// Core side (clock domain)

	// Reset release through two flops
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_ff <= 1'b0;
			rs2_ff <= 1'b0;
		end
		else
		begin
			rs1_ff <= 1'b1;
			rs2_ff <= rs1_ff;
		end
	end

	// Pin synchronisers; cs_d_ff only exists for the edge detect
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
		begin
			cs_m_ff <= 1'b1;
			cs_s_ff <= 1'b1;
			cs_d_ff <= 1'b1;
			wp_m_ff <= 1'b1;
			wp_s_ff <= 1'b1;
		end
		else
		begin
			cs_m_ff <= cs_n;
			cs_s_ff <= cs_m_ff;
			cs_d_ff <= cs_s_ff;
			wp_m_ff <= wp_n;
			wp_s_ff <= wp_m_ff;
		end
	end

	// Frame split: opcode sits just above the data bits for any count from 8 to 32,
	// so a frame cut at a bad count still decodes as the command it began as
	always_comb
	begin
		op  = shift_ff[7:0];
		d_a = shift_ff[7:0];
		d_b = shift_ff[7:0];
		if (nbits_ff > `BITS_OP && nbits_ff <= `BITS_ERASE)
			op = 8'(shift_ff >> (nbits_ff - `BITS_OP));
		if (nbits_ff == `BITS_TWO)
			d_a = shift_ff[15:8];
	end

	assign kind    = op_kind(op);
	assign cs_end  = cs_s_ff && !cs_d_ff;
	assign busy    = (wstate_ff == flash_cmd_pkg::WS_BUSY);
	// Mode 01 locks on low protect pin; modes 10/11 lock always
	assign hw_lock = status_ff[`ST_PROTECT_MODE_BIT1] || (status_ff[`ST_PROTECT_MODE_BIT0] && !wp_s_ff);
	assign can_write = !busy && status_ff[`ST_WEL] && !hw_lock;

	// Command acceptance on chip-select release, exact bit counts only
	assign start_sr0 = cs_end && kind == flash_cmd_pkg::CK_STATUS_WR0 && can_write
		&& (nbits_ff == `BITS_ONE || nbits_ff == `BITS_TWO);
	assign start_sr1 = cs_end && kind == flash_cmd_pkg::CK_STATUS_WR1 && can_write
		&& nbits_ff == `BITS_ONE;
	assign start_cr = cs_end && kind == flash_cmd_pkg::CK_CFG_WRITE && !busy
		&& status_ff[`ST_WEL] && nbits_ff == `BITS_ONE;
	assign start_erase = cs_end && kind == flash_cmd_pkg::CK_PAGE_ERASE && !busy
		&& status_ff[`ST_WEL] && nbits_ff == `BITS_ERASE;
	assign cycle_done = busy && tmr_ff == 32'(TW_CYCLES - 1);

	// New status word; protected bits keep their value, lock bits only set
	always_comb
	begin
		merged = start_sr1 ? {d_a, status_ff[7:0]} : {status_ff[15:8], d_a};
		if (nbits_ff == `BITS_TWO)
			merged = {d_b, d_a};
		merged = (merged & ~`ST_KEEP_MASK) | (status_ff & `ST_KEEP_MASK);
		merged[`ST_LB_HI:`ST_LB_LO] = merged[`ST_LB_HI:`ST_LB_LO]
			| status_ff[`ST_LB_HI:`ST_LB_LO];
		if (start_sr0 && nbits_ff == `BITS_ONE)
		begin
			merged[`ST_CMP]  = 1'b0;
			merged[`ST_QE]   = 1'b0;
			merged[`ST_PROTECT_MODE_BIT1] = 1'b0;
		end
		nxt_status = (start_sr0 || start_sr1) ? merged : status_ff;
		if (start_sr0 || start_sr1 || start_cr)
			nxt_status[`ST_WIP] = 1'b1;
		else if (cycle_done)
			nxt_status[`ST_WIP] = 1'b0;
		if (cycle_done || start_erase)
			nxt_status[`ST_WEL] = 1'b0;
		else if (cs_end && nbits_ff == `BITS_OP && !busy && kind == flash_cmd_pkg::CK_WRITE_EN)
			nxt_status[`ST_WEL] = 1'b1;
		else if (cs_end && nbits_ff == `BITS_OP && !busy && kind == flash_cmd_pkg::CK_WRITE_DIS)
			nxt_status[`ST_WEL] = 1'b0;
	end

	// Status register
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
			status_ff <= `STATUS_RESET;
		else
			status_ff <= nxt_status;
	end

	// Configure register; reserved bits stay zero
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
			cfg_ff <= `CFG_RESET;
		else if (start_cr)
			cfg_ff <= d_a & `CF_WR_MASK;
	end

	// Self-timed write cycle
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
		begin
			wstate_ff <= flash_cmd_pkg::WS_IDLE;
			tmr_ff    <= 32'h0000_0000;
		end
		else
		begin
			case (wstate_ff)
				flash_cmd_pkg::WS_IDLE:
				begin
					tmr_ff <= 32'h0000_0000;
					if (start_sr0 || start_sr1 || start_cr)
						wstate_ff <= flash_cmd_pkg::WS_BUSY;
				end
				flash_cmd_pkg::WS_BUSY:
				begin
					tmr_ff <= tmr_ff + 32'h0000_0001;
					if (cycle_done)
						wstate_ff <= flash_cmd_pkg::WS_IDLE;
				end
				default:
					wstate_ff <= flash_cmd_pkg::WS_IDLE;
			endcase
		end
	end

	// Pin function, strength, page size and scheme from config/status
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
		begin
			hold_fn        <= 1'b0;
			reset_fn       <= 1'b0;
			quad_io        <= 1'b0;
			drive_level    <= flash_cmd_pkg::DRV_100;
			page_1k        <= 1'b0;
			lock_by_blocks <= 1'b0;
			buf_addr       <= 10'h000;
			status_word    <= `STATUS_RESET;
		end
		else
		begin
			quad_io  <= status_ff[`ST_QE];
			hold_fn  <= !status_ff[`ST_QE] && !cfg_ff[`CF_HOLD_RST];
			reset_fn <= !status_ff[`ST_QE] && cfg_ff[`CF_HOLD_RST];
			case ({cfg_ff[`CF_DRV_HI], cfg_ff[`CF_DRV_LO]})
				2'b00:   drive_level <= flash_cmd_pkg::DRV_50;
				2'b01:   drive_level <= flash_cmd_pkg::DRV_150;
				2'b11:   drive_level <= flash_cmd_pkg::DRV_75;
				default: drive_level <= flash_cmd_pkg::DRV_100;
			endcase
			if (D_VARIANT)
				drive_level <= flash_cmd_pkg::DRV_100;
			page_1k        <= cfg_ff[`CF_QP];
			// Legacy 256-byte wrap unless the quad page is on
			buf_addr       <= load_addr & (cfg_ff[`CF_QP] ? `PAGE_MASK_1K : `PAGE_MASK_256);
			lock_by_blocks <= cfg_ff[`CF_WPS];
			status_word    <= status_ff;
		end
	end

	// Page erase request; span follows the quad page bit
	always_ff @(posedge clock or negedge rs2_ff)
	begin
		if (!rs2_ff)
		begin
			erase_req  <= 1'b0;
			erase_quad <= 1'b0;
		end
		else
		begin
			erase_req <= start_erase;
			if (start_erase)
				erase_quad <= cfg_ff[`CF_QP];
		end
	end

	// Individual block locks, all locked out of reset
	genvar gi;
	generate
		for (gi = 0; gi < `LOCK_BITS; gi++)
		begin : g_lock
			always_ff @(posedge clock or negedge rs2_ff)
			begin
				if (!rs2_ff)
					block_lock[gi] <= 1'b1;
				else if (lock_wr && lock_idx == 4'(gi))
					block_lock[gi] <= lock_val;
			end
		end
	endgenerate

	// ==========================================================
	// Assertions
	a_wel_gate: assert property (@(posedge clock) disable iff (!rs2_ff)
		(cs_end && kind == flash_cmd_pkg::CK_STATUS_WR0 && !status_ff[`ST_WEL] && !busy)
		|=> !busy && $stable(status_ff[15:2]))
		else $error("status write taken without write enable");
	a_keep_bits: assert property (@(posedge clock) disable iff (!rs2_ff)
		(start_sr0 || start_sr1) |=> status_ff[15] == $past(status_ff[15])
		&& status_ff[10] == $past(status_ff[10]) && status_ff[`ST_WEL])
		else $error("status write touched a kept bit");
	a_eight_clear: assert property (@(posedge clock) disable iff (!rs2_ff)
		(start_sr0 && nbits_ff == `BITS_ONE)
		|=> !status_ff[`ST_CMP] && !status_ff[`ST_QE] && !status_ff[`ST_PROTECT_MODE_BIT1])
		else $error("short status write did not clear bits");
	a_bad_count: assert property (@(posedge clock) disable iff (!rs2_ff)
		(cs_end && kind == flash_cmd_pkg::CK_STATUS_WR0 && nbits_ff != `BITS_ONE
		&& nbits_ff != `BITS_TWO && !busy) |=> !busy)
		else $error("status write with bad bit count accepted");
	a_hw_lock: assert property (@(posedge clock) disable iff (!rs2_ff)
		(cs_end && hw_lock && !busy) |=> !busy && $stable(status_ff[15:2]))
		else $error("write accepted in protected mode");
	a_cycle_len: assert property (@(posedge clock) disable iff (!rs2_ff)
		$rose(status_ff[`ST_WIP]) |-> status_ff[`ST_WIP] [*8])
		else $error("write cycle ended early");
	a_cycle_end: assert property (@(posedge clock) disable iff (!rs2_ff)
		$fell(status_ff[`ST_WIP]) |-> !status_ff[`ST_WEL] && $past(tmr_ff) == 32'(TW_CYCLES - 1))
		else $error("write cycle end wrong");
	a_pin_func: assert property (@(posedge clock) disable iff (!rs2_ff)
		quad_io |-> !hold_fn && !reset_fn)
		else $error("hold or reset active in quad mode");
	a_page_wrap: assert property (@(posedge clock) disable iff (!rs2_ff)
		!page_1k && !$past(cfg_ff[`CF_QP]) |-> buf_addr[9:8] == 2'b00)
		else $error("load address passed 256-byte wrap");
	a_int_falls: assert property (@(posedge clock) disable iff (!rs2_ff)
		(so_oe && mode_ff == flash_cmd_pkg::LK_ASI && !so) |=> (!so || !so_oe))
		else $error("ready output rose during interrupt");

	c_short_write: cover property (@(posedge clock) disable iff (!rs2_ff)
		start_sr0 && nbits_ff == `BITS_ONE);
	c_long_write: cover property (@(posedge clock) disable iff (!rs2_ff)
		start_sr0 && nbits_ff == `BITS_TWO);
	c_int_ready: cover property (@(posedge clock) disable iff (!rs2_ff)
		so_oe && mode_ff == flash_cmd_pkg::LK_ASI && $fell(status_ff[`ST_WIP]));
	c_cfg_read: cover property (@(posedge clock) disable iff (!rs2_ff)
		so_oe && mode_ff == flash_cmd_pkg::LK_CFG && busy);

endmodule

`default_nettype wire

// File: tb/spi_host_model.sv
// Purpose: Behavioural SPI host, mode 0, driving the flash command block
// Assumes: sck period 80 ns, sck stands low outside frames
// Notes:   si shows the inverse of its last bit once it is of no use
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	// ==========================================================
	// Frame engine
	logic [15:0] rd_val;
	event        rd_done;

	// Idle bus; cs_n rises just after time zero so the link flops see a clean edge
	initial
	begin
		sck = 1'b0;
		si = 1'b0;
		rd_val = 16'h0000;
		#1 cs_n = 1'b1;
	end

	// n bits out MSB first, then nrd bits sampled on rising sck
	task automatic xfer(input logic [31:0] d, input int n, input int nrd, input bit keep);
		int i;
		cs_n = 1'b0;
		#40;
		for (i = 0; i < n + nrd; i++)
		begin
			si = (i < n) ? d[31 - i] : ~si; // No dummy bit in mode 0
			#40 sck = 1'b1;
			if (i >= n)
				rd_val = {rd_val[14:0], so};
			#40 sck = 1'b0;
		end
		if (nrd > 0)
			-> rd_done;
		if (!keep)
			release_cs();
	endtask

	// Rise 40 ns after the call, then a gap the core can see
	task automatic release_cs();
		#40 cs_n = 1'b1;
		si = ~si;
		#100;
	endtask
endmodule
`default_nettype wire

// File: tb/tb_flash_config_status_register_cmds.sv
// Purpose: Self-checking bench for the config/status command block
// Assumes: Short write cycle through TW_CYCLES, host model in mode 0
// Notes:   Read results and erase pulses are matched against queued notes
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"
module tb_flash_config_status_register_cmds;
	// ==========================================================
	// Signals
	localparam int TW = 200;
	logic clock = 1'b0;
	logic rst_n, sck, cs_n, si, so, so_oe, wp_n, lock_wr, lock_val;
	logic hold_fn, reset_fn, quad_io, page_1k, lock_by_blocks, erase_req, erase_quad;
	logic [3:0] lock_idx;
	logic [9:0] load_addr, buf_addr, la;
	logic [15:0] block_lock, status_word, st;
	logic [15:0] exp_q[$];
	logic [7:0] b;
	flash_cmd_pkg::strength_t drive_level;
	flash_cmd_pkg::strength_t drive_level_d;
	logic so_d, so_oe_d;
	flash_cmd_pkg::strength_t drv [4] = '{flash_cmd_pkg::DRV_50, flash_cmd_pkg::DRV_150,
		flash_cmd_pkg::DRV_100, flash_cmd_pkg::DRV_75};
	int err_total = 0;
	int n_tests = 0;
	int i;

	// Clock at 50 MHz
	always #10 clock = ~clock;

	flash_config_status_register_cmds #(.D_VARIANT(1'b0), .TW_CYCLES(TW)) dut (
		.clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe), .wp_n(wp_n), .load_addr(load_addr), .lock_wr(lock_wr),
		.lock_idx(lock_idx), .lock_val(lock_val), .hold_fn(hold_fn), .reset_fn(reset_fn),
		.quad_io(quad_io), .drive_level(drive_level), .page_1k(page_1k),
		.buf_addr(buf_addr), .lock_by_blocks(lock_by_blocks), .block_lock(block_lock),
		.erase_req(erase_req), .erase_quad(erase_quad), .status_word(status_word)
	);

	// Second build with the D ordering option on the same link
	flash_config_status_register_cmds #(.D_VARIANT(1'b1), .TW_CYCLES(TW)) dut_d (
		.clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so_d),
		.so_oe(so_oe_d), .wp_n(wp_n), .load_addr(load_addr), .lock_wr(lock_wr),
		.lock_idx(lock_idx), .lock_val(lock_val), .hold_fn(), .reset_fn(), .quad_io(),
		.drive_level(drive_level_d), .page_1k(), .buf_addr(), .lock_by_blocks(),
		.block_lock(), .erase_req(), .erase_quad(), .status_word()
	);

	spi_host_model host (.cs_n(cs_n), .sck(sck), .si(si), .so(so));

	// ==========================================================
	// Helpers
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	// Enable frame, write frame, then sit out the timed cycle
	task automatic wr(input logic [7:0] op, input logic [15:0] d, input int nb);
		host.xfer({`OP_WRITE_EN, 24'h0}, 8, 0, 1'b0);
		host.xfer({op, d, 8'h00}, 8 + nb, 0, 1'b0);
		cyc(TW + 10);
	endtask

	task automatic rd_cfg(input logic [7:0] e);
		exp_q.push_back({e, e});
		host.xfer({`OP_CFG_READ, 24'h0}, 8, 16, 1'b0);
	endtask

	task automatic results();
		if (err_total == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Oldest note against each finished read or erase pulse
	initial
	forever
	begin
		@(host.rd_done or posedge erase_req);
		#1;
		chk("result", (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx,
			(erase_req === 1'b1) ? 16'(erase_quad) : host.rd_val);
	end

	// Cut a hang short
	initial
	begin
		#1ms;
		err_total++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		wp_n = 1'b1;
		load_addr = 10'h000;
		lock_wr = 1'b0;
		lock_idx = 4'h0;
		lock_val = 1'b1;
		st = 16'h0000;
		void'($urandom(32'h38f4ddb8));
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		chk("status_word", st, status_word);
		chk("block_lock", 16'hffff, block_lock);
		chk("drive_level", 16'(flash_cmd_pkg::DRV_100), 16'(drive_level));
		chk("pins", 16'h0002, 16'({quad_io, hold_fn, reset_fn}));
		chk("page_1k", 16'h0000, 16'(page_1k));
		rd_cfg(`CFG_RESET);
		// Write without enable is dropped
		b = 8'($urandom) & 8'h7c;
		host.xfer({`OP_STATUS_WR0, b, 16'h0}, 16, 0, 1'b0);
		cyc(20);
		chk("status_word", st, status_word);
		// Busy cycle, read while busy, ready interrupt
		host.xfer({`OP_WRITE_EN, 24'h0}, 8, 0, 1'b0);
		chk("wel", 16'h0002, status_word);
		host.xfer({`OP_STATUS_WR0, b, 16'h0}, 16, 0, 1'b0);
		cyc(2);
		chk("busy", 16'h0003, 16'(status_word[1:0]));
		rd_cfg(`CFG_RESET);
		host.xfer({`OP_READY_INT, 24'h0}, 8, 0, 1'b1);
		#1;
		chk("ready_out", 16'h0003, 16'({so_oe, so}));
		for (i = 0; i < TW && so === 1'b1; i++)
			cyc(1);
		cyc(2);
		chk("ready_low", 16'h0000, 16'(so));
		st = {8'h00, b};
		chk("status_word", st, status_word);
		host.release_cs();
		chk("so_oe", 16'h0000, 16'(so_oe));
		// Two bytes, high byte alone, then eight bits clearing
		wr(`OP_STATUS_WR0, {b, 8'hc6}, 16);
		st = {8'h42, b};
		chk("status_word", st, status_word);
		chk("pins", 16'h0004, 16'({quad_io, hold_fn, reset_fn}));
		wr(`OP_STATUS_WR1, {8'h4a, 8'h00}, 8);
		st[15:8] = 8'h4a;
		chk("status_word", st, status_word);
		wr(`OP_STATUS_WR0, {b, 8'h00}, 8);
		st[15:8] = 8'h08;
		chk("status_word", st, status_word);
		// Twelve data bits are refused, enable latch stays
		host.xfer({`OP_WRITE_EN, 24'h0}, 8, 0, 1'b0);
		host.xfer({`OP_STATUS_WR0, ~b, 16'h0}, 20, 0, 1'b0);
		cyc(TW);
		chk("status_word", st | 16'h0002, status_word);
		// Hardware protection through the write-protect pin
		wr(`OP_STATUS_WR0, {8'h80, 8'h00}, 8);
		st[7:0] = 8'h80;
		chk("status_word", st, status_word);
		wp_n = 1'b0;
		wr(`OP_STATUS_WR0, {8'h10, 8'h00}, 8);
		chk("status_word", st | 16'h0002, status_word);
		wp_n = 1'b1;
		cyc(4);
		wr(`OP_STATUS_WR0, {8'h00, 8'h00}, 8);
		st[7:0] = 8'h00;
		chk("status_word", st, status_word);
		// Every drive code with quad page and block locks on
		for (i = 0; i < 4; i++)
		begin
			b = {1'b1, 2'(i), 5'b10100};
			wr(`OP_CFG_WRITE, {b, 8'h00}, 8);
			chk("drive_level", 16'(drv[i]), 16'(drive_level));
			chk("drive_level_d", 16'(flash_cmd_pkg::DRV_100), 16'(drive_level_d));
			chk("cfg_pins", 16'h000b, 16'({reset_fn, hold_fn, page_1k, lock_by_blocks}));
			rd_cfg(b);
		end
		// The D build answers 45h, the default build stays silent
		host.xfer({`OP_CFG_READ_D, 24'h0}, 8, 0, 1'b1);
		#1;
		chk("cfg_read_d", 16'h0003, 16'({so_oe_d, so_d}));
		chk("so_oe", 16'h0000, 16'(so_oe));
		host.release_cs();
		chk("status_word", st, status_word);
		// Load address wrap and erase size for both page sizes
		la = 10'($urandom);
		load_addr = la;
		cyc(2);
		chk("buf_addr", 16'(la), 16'(buf_addr));
		exp_q.push_back(16'h0001);
		wr(`OP_PAGE_ERASE, 16'($urandom), 24);
		wr(`OP_CFG_WRITE, {8'h40, 8'h00}, 8);
		chk("buf_addr", 16'(la & 10'h0ff), 16'(buf_addr));
		exp_q.push_back(16'h0000);
		wr(`OP_PAGE_ERASE, 16'($urandom), 24);
		// Clear one block lock
		lock_idx = 4'($urandom);
		lock_val = 1'b0;
		lock_wr = 1'b1;
		cyc(1);
		lock_wr = 1'b0;
		cyc(2);
		chk("block_lock", ~(16'h0001 << lock_idx), block_lock);
		// Reset in mid-run locks every block again
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		cyc(4);
		chk("block_lock", 16'hffff, block_lock);
		chk("notes_left", 16'h0000, 16'(exp_q.size()));
		results();
	end
endmodule
`default_nettype wire
